// file: core/clock_ctl_consts.svh
// Offsets, field positions, reset values and timing counts for the clock control block
`ifndef CLOCK_CTL_CONSTS_SVH
`define CLOCK_CTL_CONSTS_SVH
`define CC_OFF_MODE_A 5'h00
`define CC_OFF_MODE_B 5'h04
`define CC_OFF_MODE_C 5'h08
`define CC_OFF_PROC_C 5'h0C
`define CC_OFF_CMD 5'h10
`define CC_OFF_STAT 5'h14
`define CC_BIT_PSTOP 2
`define CC_BIT_DIV8 6
`define CC_BIT_OFF 0
`define CC_BIT_RLO 6
`define CC_BIT_RHI 7
`define CC_BIT_SRC 1
`define CC_BIT_WDS 2
`define CC_BIT_WAIT 0
`define CC_RST_DIV8 1'h1
`define CC_RST_RATIO 2'h0
`define CC_MASK_DIV8 4'h7
`define CC_CLK_NS 10
`define CC_ROSC_NS 1000
`define CC_ROSC_CYC (`CC_ROSC_NS / `CC_CLK_NS)
`define CC_MAIN_MUL 17'h00003
`define CC_PER_MIN 16'h0003
`define CC_PER_RST 16'h001E
`define CC_PRE_WRAP 5'h1F
`define CC_ALIGN 4'hF
`endif

// file: core/clock_ctl_pkg.sv
// Types shared by the clock control block
package clock_ctl_pkg;
  typedef enum logic [2:0] {
    ST_RUN = 3'b001,
    ST_WAIT = 3'b010,
    ST_STOP = 3'b100
  } pwr_state_t;
endpackage : clock_ctl_pkg

// file: core/cpu_clock_select_and_wait_power_control.sv
// What this block does
// [RL1] Main clock runs at triple oscillator rate
// [RL2] Main clock keeps running if oscillator stops
// [RL3] After reset CPU clock is main divided by eight
// [RL4] Internal oscillator off at reset, select bit starts it
// [RL5] Watchdog source bit picks internal oscillator, counts in wait if select bit has started it
// [RL6] CPU divider ratios 1, 2, 4, 8, 16
// [RL7] Divide-by-eight bit wins, else two-bit ratio field
// [RL8] Entering stop sets divide-by-eight bit
// [RL9] Peripheral clocks divide source by 1, 2, 8, 32
// [RL10] Clock-stop bit gates peripheral clocks during wait
// [RL11] Wait command enters wait mode
// [RL12] Wait stops CPU clock and usual watchdog clock
// [RL13] Main and internal oscillator keep running in wait
// [RL14] Port pins hold their state in wait
// [RL15] Reset or interrupt ends wait mode
// [RL16] Clock-stop bit limits wake to external sources
// [RL17] Interrupt wake restarts CPU clock first
// [RL18] Source and divider unchanged across wait
// [RL19] Software disables interrupts before reset-only wait
// [RL20] Software prepares wake interrupt before wait
// [RL21] Software switches only to stable sources
// [RL22] Software sets divide-by-eight before leaving internal oscillator
// [RL23] Stop mode turns off every core clock
// [RL24] All-clocks-off bit enters stop, sets divide-by-eight
// [RL25] Source and ratio changes cause no runt pulses
`timescale 1ns/1ps
`include "clock_ctl_consts.svh"
module cpu_clock_select_and_wait_power_control
  import clock_ctl_pkg::*;
(
  input wire logic mclk_i,
  input wire logic reset_i,
  input wire logic osc_input_i,
  output logic osc_output_o,
  input wire logic [4:0] avs_address_i,
  input wire logic avs_read_i,
  input wire logic avs_write_i,
  input wire logic [31:0] avs_writedata_i,
  input wire logic [3:0] avs_byteenable_i,
  output logic [31:0] avs_readdata_o,
  output logic avs_waitrequest_o,
  input wire logic irq_req_i,
  input wire logic ext_irq_req_i,
  output logic main_clk_tick_o,
  output logic ring_tick_o,
  output logic ring_on_o,
  output logic cpu_clk_en_o,
  output logic wdt_clk_en_o,
  output logic f1_o,
  output logic f2_o,
  output logic f8_o,
  output logic f32_o,
  output logic serial_clk_div_one_o,
  output logic serial_clk_div_two_o,
  output logic serial_clk_div_eight_o,
  output logic serial_clk_div_thirtytwo_o,
  output logic cpu_halt_o,
  output logic port_hold_o
);
  localparam logic [6:0] ROSC_LAST = 7'(`CC_ROSC_CYC - 1);
  localparam logic [4:0] PMASK [4] = '{5'h00, 5'h01, 5'h07, 5'h1F};

  pwr_state_t state_reg, state_next;
  logic ack_reg, ack_next;
  logic [31:0] rdata_reg, rdata_next;
  logic div8_reg, div8_next;
  logic [1:0] ratio_reg, ratio_next;
  logic pstop_reg, pstop_next;
  logic src_reg, src_next;
  logic wds_reg, wds_next;
  logic pstop_wait_reg, pstop_wait_next;
  logic req, wr_ok, run, pgate, src_tick, cpu_hit;
  logic [3:0] cfg_mask;

  logic osc_prev_reg, osc_prev_next;
  logic osc_out_reg, osc_out_next;
  logic [15:0] per_cnt_reg, per_cnt_next;
  logic [15:0] per_reg, per_next;
  logic [16:0] acc_reg, acc_next, acc_sum;
  logic main_tick_reg, main_tick_next;
  logic [6:0] ring_cnt_reg, ring_cnt_next;
  logic ring_tick_reg, ring_tick_next;
  logic [4:0] pre_reg, pre_next;
  logic src_act_reg, src_act_next;
  logic [3:0] mask_reg, mask_next;
  logic cpu_tick_reg, cpu_tick_next;
  logic wdt_tick_reg, wdt_tick_next;
  logic [3:0] fi_reg, fi_next;

  // Avalon slave: one wait cycle per access
  assign req = avs_read_i | avs_write_i;
  assign avs_waitrequest_o = req & ~ack_reg;
  assign wr_ok = avs_write_i & ack_reg & avs_byteenable_i[0];
  assign run = (state_reg == ST_RUN);
  assign avs_readdata_o = rdata_reg;

  always_comb begin
    ack_next = req & ~ack_reg;
    rdata_next = rdata_reg;
    if (avs_read_i & ~ack_reg) begin
      rdata_next = 32'h00000000;
      unique case (avs_address_i)
        `CC_OFF_MODE_A: begin
          rdata_next[`CC_BIT_DIV8] = div8_reg;
          rdata_next[`CC_BIT_PSTOP] = pstop_reg;
        end
        `CC_OFF_MODE_B: begin
          rdata_next[`CC_BIT_RHI] = ratio_reg[1];
          rdata_next[`CC_BIT_RLO] = ratio_reg[0];
          rdata_next[`CC_BIT_OFF] = (state_reg == ST_STOP);
        end
        `CC_OFF_MODE_C: rdata_next[`CC_BIT_SRC] = src_reg;
        `CC_OFF_PROC_C: rdata_next[`CC_BIT_WDS] = wds_reg;
        `CC_OFF_STAT: rdata_next = {24'h000000, mask_reg, src_act_reg, ring_on_o,
          (state_reg == ST_STOP), (state_reg == ST_WAIT)};
        default: rdata_next = 32'h00000000;
      endcase
    end
  end

  // Mode registers and power state
  always_comb begin
    state_next = state_reg;
    div8_next = div8_reg;
    ratio_next = ratio_reg;
    pstop_next = pstop_reg;
    src_next = src_reg;
    wds_next = wds_reg;
    pstop_wait_next = pstop_wait_reg;
    unique case (state_reg)
      ST_RUN: begin
        if (wr_ok) begin
          unique case (avs_address_i)
            `CC_OFF_MODE_A: begin
              div8_next = avs_writedata_i[`CC_BIT_DIV8];
              pstop_next = avs_writedata_i[`CC_BIT_PSTOP];
            end
            `CC_OFF_MODE_B: begin
              ratio_next = {avs_writedata_i[`CC_BIT_RHI], avs_writedata_i[`CC_BIT_RLO]};
              if (avs_writedata_i[`CC_BIT_OFF]) begin
                state_next = ST_STOP; // RL24
                div8_next = 1'b1; // RL8
              end
            end
            `CC_OFF_MODE_C: src_next = avs_writedata_i[`CC_BIT_SRC]; // RL4
            `CC_OFF_PROC_C: wds_next = avs_writedata_i[`CC_BIT_WDS]; // RL5
            `CC_OFF_CMD: begin
              if (avs_writedata_i[`CC_BIT_WAIT]) begin
                state_next = ST_WAIT; // RL11
                pstop_wait_next = pstop_reg; // RL10
              end
            end
            default: state_next = ST_RUN;
          endcase
        end
      end
      ST_WAIT: begin
        if (ext_irq_req_i | (irq_req_i & ~pstop_wait_reg)) begin
          state_next = ST_RUN; // RL15 RL16 RL17
        end
      end
      ST_STOP: begin
        if (ext_irq_req_i) begin
          state_next = ST_RUN;
        end
      end
    endcase
  end

  always_ff @(posedge mclk_i) begin
    if (reset_i) begin
      ack_reg <= 1'b0;
      rdata_reg <= 32'h00000000;
      state_reg <= ST_RUN;
      div8_reg <= `CC_RST_DIV8; // RL3
      ratio_reg <= `CC_RST_RATIO;
      pstop_reg <= 1'b0;
      src_reg <= 1'b0; // RL4
      wds_reg <= 1'b0;
      pstop_wait_reg <= 1'b0;
    end else begin
      ack_reg <= ack_next;
      rdata_reg <= rdata_next;
      state_reg <= state_next;
      div8_reg <= div8_next;
      ratio_reg <= ratio_next;
      pstop_reg <= pstop_next;
      src_reg <= src_next;
      wds_reg <= wds_next;
      pstop_wait_reg <= pstop_wait_next;
    end
  end

  // Ratio decode
  always_comb begin
    if (div8_reg) begin
      cfg_mask = `CC_MASK_DIV8; // RL7
    end else begin
      unique case (ratio_reg) // RL6 RL7
        2'h0: cfg_mask = 4'h0;
        2'h1: cfg_mask = 4'h1;
        2'h2: cfg_mask = 4'h3;
        2'h3: cfg_mask = 4'hF;
      endcase
    end
  end

  assign ring_on_o = (src_reg | src_act_reg) & (state_reg != ST_STOP); // RL4 RL13 RL23 RL25
  assign src_tick = src_act_reg ? ring_tick_reg : main_tick_reg;
  assign pgate = (state_reg == ST_STOP) | ((state_reg == ST_WAIT) & pstop_wait_reg); // RL10
  assign cpu_hit = src_tick & ((pre_reg[3:0] & mask_reg) == mask_reg);
  assign acc_sum = acc_reg + `CC_MAIN_MUL;

  // Clock generation
  always_comb begin
    osc_prev_next = osc_input_i;
    osc_out_next = ~osc_input_i & (state_reg != ST_STOP);
    per_cnt_next = (per_cnt_reg == 16'hFFFF) ? per_cnt_reg : per_cnt_reg + 16'h0001;
    per_next = per_reg;
    if (osc_input_i & ~osc_prev_reg) begin
      per_cnt_next = 16'h0000;
      per_next = (per_cnt_reg < `CC_PER_MIN) ? `CC_PER_MIN : per_cnt_reg + 16'h0001; // RL1
    end
    acc_next = acc_reg;
    main_tick_next = 1'b0;
    if (state_reg != ST_STOP) begin // RL2 RL23
      acc_next = acc_sum;
      if (acc_sum >= {1'b0, per_reg}) begin
        acc_next = acc_sum - {1'b0, per_reg}; // RL1
        main_tick_next = 1'b1;
      end
    end
    ring_cnt_next = 7'h00;
    ring_tick_next = 1'b0;
    if (ring_on_o) begin
      ring_cnt_next = (ring_cnt_reg == ROSC_LAST) ? 7'h00 : ring_cnt_reg + 7'h01;
      ring_tick_next = (ring_cnt_reg == ROSC_LAST);
    end
    pre_next = src_tick ? pre_reg + 5'h01 : pre_reg;
    src_act_next = src_act_reg;
    mask_next = mask_reg;
    if (src_tick & (pre_reg[3:0] == `CC_ALIGN)) begin
      mask_next = cfg_mask; // RL25
    end
    if (src_tick & (pre_reg == `CC_PRE_WRAP)) begin
      src_act_next = src_reg; // RL25
    end
    cpu_tick_next = cpu_hit & run; // RL12
    wdt_tick_next = wds_reg ? ring_tick_reg : cpu_tick_next; // RL5 RL12
  end

  generate
    for (genvar g = 0; g < 4; g++) begin : g_fi
      assign fi_next[g] = src_tick & ~pgate & ((pre_reg & PMASK[g]) == PMASK[g]); // RL9 RL10
    end
  endgenerate

  always_ff @(posedge mclk_i) begin
    if (reset_i) begin
      osc_prev_reg <= 1'b0;
      osc_out_reg <= 1'b0;
      per_cnt_reg <= 16'h0000;
      per_reg <= `CC_PER_RST;
      acc_reg <= 17'h00000;
      main_tick_reg <= 1'b0;
      ring_cnt_reg <= 7'h00;
      ring_tick_reg <= 1'b0;
      pre_reg <= 5'h00;
      src_act_reg <= 1'b0;
      mask_reg <= `CC_MASK_DIV8; // RL3
      cpu_tick_reg <= 1'b0;
      wdt_tick_reg <= 1'b0;
      fi_reg <= 4'h0;
    end else begin
      osc_prev_reg <= osc_prev_next;
      osc_out_reg <= osc_out_next;
      per_cnt_reg <= per_cnt_next;
      per_reg <= per_next;
      acc_reg <= acc_next;
      main_tick_reg <= main_tick_next;
      ring_cnt_reg <= ring_cnt_next;
      ring_tick_reg <= ring_tick_next;
      pre_reg <= pre_next;
      src_act_reg <= src_act_next;
      mask_reg <= mask_next;
      cpu_tick_reg <= cpu_tick_next;
      wdt_tick_reg <= wdt_tick_next;
      fi_reg <= fi_next;
    end
  end

  assign osc_output_o = osc_out_reg;
  assign main_clk_tick_o = main_tick_reg;
  assign ring_tick_o = ring_tick_reg;
  assign cpu_clk_en_o = cpu_tick_reg;
  assign wdt_clk_en_o = wdt_tick_reg;
  assign f1_o = fi_reg[0];
  assign f2_o = fi_reg[1];
  assign f8_o = fi_reg[2];
  assign f32_o = fi_reg[3];
  assign serial_clk_div_one_o = fi_reg[0];
  assign serial_clk_div_two_o = fi_reg[1];
  assign serial_clk_div_eight_o = fi_reg[2];
  assign serial_clk_div_thirtytwo_o = fi_reg[3];
  assign cpu_halt_o = ~run; // RL12
  assign port_hold_o = (state_reg == ST_WAIT); // RL14

  // Checks
  sequence seq_wait_cmd;
    run && wr_ok && avs_address_i == `CC_OFF_CMD && avs_writedata_i[`CC_BIT_WAIT];
  endsequence

  sequence seq_stop_cmd;
    run && wr_ok && avs_address_i == `CC_OFF_MODE_B && avs_writedata_i[`CC_BIT_OFF];
  endsequence

  sequence seq_int_wake;
    state_reg == ST_WAIT && irq_req_i && !pstop_wait_reg;
  endsequence

  AST_RESET_DIV8: assert property (@(posedge mclk_i) disable iff (reset_i) // RL3
    $past(reset_i) |-> div8_reg && !src_reg && mask_reg == `CC_MASK_DIV8 && !ring_on_o)
    else $error("reset state is not main clock divided by eight");

  AST_WAIT_ENTRY: assert property (@(posedge mclk_i) disable iff (reset_i) // RL11
    seq_wait_cmd |=> state_reg == ST_WAIT ##1 (!cpu_clk_en_o || state_reg != ST_WAIT))
    else $error("wait command did not enter wait mode");

  AST_STOP_DIV8: assert property (@(posedge mclk_i) disable iff (reset_i) // RL24
    seq_stop_cmd |=> state_reg == ST_STOP && div8_reg && !ring_on_o)
    else $error("stop entry did not set divide by eight");

  AST_CPU_OFF: assert property (@(posedge mclk_i) disable iff (reset_i) // RL12
    (state_reg != ST_RUN) [*2] |-> !cpu_clk_en_o && (wds_reg || !wdt_clk_en_o))
    else $error("cpu clock ran while halted");

  AST_PERIPH_GATE: assert property (@(posedge mclk_i) disable iff (reset_i) // RL10
    (state_reg == ST_WAIT && pstop_wait_reg) [*2] |-> !f1_o && !f32_o)
    else $error("peripheral clock ran during gated wait");

  AST_WAKE_EXT: assert property (@(posedge mclk_i) disable iff (reset_i) // RL15
    state_reg == ST_WAIT && ext_irq_req_i |=> run)
    else $error("external interrupt did not end wait");

  AST_NO_WAKE_INT: assert property (@(posedge mclk_i) disable iff (reset_i) // RL16
    state_reg == ST_WAIT && pstop_wait_reg && !ext_irq_req_i |=> state_reg == ST_WAIT)
    else $error("internal interrupt woke gated wait");

  AST_KEEP_CFG: assert property (@(posedge mclk_i) disable iff (reset_i) // RL18
    state_reg == ST_WAIT |=> $stable(div8_reg) && $stable(ratio_reg) && $stable(src_reg))
    else $error("clock setting changed during wait");

  AST_RING_WAIT: assert property (@(posedge mclk_i) disable iff (reset_i) // RL13
    state_reg == ST_WAIT && src_reg |-> ring_on_o)
    else $error("internal oscillator stopped in wait");

  AST_F32_ALIGN: assert property (@(posedge mclk_i) disable iff (reset_i) // RL9
    f32_o |-> f8_o && f2_o && f1_o)
    else $error("divided clocks not aligned");

  AST_WAKE_INT: assert property (@(posedge mclk_i) disable iff (reset_i) // RL16
    seq_int_wake |=> run && !port_hold_o)
    else $error("peripheral interrupt did not end ungated wait");

  AST_SRC_RING: assert property (@(posedge mclk_i) disable iff (reset_i) // RL25
    src_act_reg && state_reg != ST_STOP |-> ring_on_o)
    else $error("internal oscillator stopped while still the active source");

  AST_STOP_QUIET: assert property (@(posedge mclk_i) disable iff (reset_i) // RL23
    (state_reg == ST_STOP) [*2] |-> !main_clk_tick_o && !f1_o && !osc_output_o)
    else $error("clock activity during stop");

  AST_WDT_RING: assert property (@(posedge mclk_i) disable iff (reset_i) // RL5
    wds_reg && ring_tick_o |=> wdt_clk_en_o)
    else $error("watchdog missed an internal oscillator tick");
endmodule : cpu_clock_select_and_wait_power_control

// file: testbench/osc_partner.sv
// Oscillator source model that drives the clock block's oscillator input
`timescale 1ns/1ps
module osc_partner (
  input wire logic mclk_i,
  input wire logic run_i,
  input wire logic [7:0] half_i,
  output logic osc_o
);
  logic [7:0] cnt_reg;
  initial begin
    osc_o = 1'h0;
    cnt_reg = 8'h00;
  end
  // Steady square wave, level held when stopped
  always @(posedge mclk_i) begin
    if (run_i) begin
      if (cnt_reg + 8'h01 >= half_i) begin
        cnt_reg <= 8'h00;
        osc_o <= ~osc_o;
      end else begin
        cnt_reg <= cnt_reg + 8'h01;
      end
    end
  end
endmodule : osc_partner

// file: testbench/tb_top.sv
// Self-checking bench for the clock select and wait control block
`timescale 1ns/1ps
`include "clock_ctl_consts.svh"
module tb_top;
  logic mclk_i, reset_i, osc_run, osc_in, osc_out, rd_req, wr_req, waitreq, irq, ext_irq;
  logic main_t, ring_t, ring_on, cpu_en, wdt_en, f1, f2, f8, f32, s1, s2, s8, s32, halt, hold;
  logic [7:0] osc_half;
  logic [4:0] addr;
  logic [31:0] wdata, rdata, rd;
  logic [2:0] b;
  int error_cnt, comparisons, h, s, r;
  int cnt[12];
  logic [2:0] tbl[6] = '{3'h4, 3'h0, 3'h1, 3'h2, 3'h3, 3'h7};
  int fdiv[4] = '{1, 2, 8, 32};

  osc_partner osc_partner_inst (.mclk_i(mclk_i), .run_i(osc_run), .half_i(osc_half),
    .osc_o(osc_in));

  cpu_clock_select_and_wait_power_control cpu_clock_select_and_wait_power_control_inst (
    .mclk_i(mclk_i), .reset_i(reset_i), .osc_input_i(osc_in), .osc_output_o(osc_out),
    .avs_address_i(addr), .avs_read_i(rd_req), .avs_write_i(wr_req),
    .avs_writedata_i(wdata), .avs_byteenable_i(4'hF), .avs_readdata_o(rdata),
    .avs_waitrequest_o(waitreq), .irq_req_i(irq), .ext_irq_req_i(ext_irq),
    .main_clk_tick_o(main_t), .ring_tick_o(ring_t), .ring_on_o(ring_on),
    .cpu_clk_en_o(cpu_en), .wdt_clk_en_o(wdt_en), .f1_o(f1), .f2_o(f2), .f8_o(f8),
    .f32_o(f32), .serial_clk_div_one_o(s1), .serial_clk_div_two_o(s2),
    .serial_clk_div_eight_o(s8), .serial_clk_div_thirtytwo_o(s32), .cpu_halt_o(halt),
    .port_hold_o(hold));

  initial begin
    mclk_i = 1'h0;
    forever #5 mclk_i = ~mclk_i;
  end

  task automatic tally_and_finish();
    $display("Comparisons %0d, mismatches %0d", comparisons, error_cnt);
    if (error_cnt == 0 && comparisons > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : tally_and_finish

  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      error_cnt++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : check

  task automatic bus(input logic wr, input logic [4:0] a, input logic [31:0] d);
    int t;
    logic w;
    @(posedge mclk_i);
    addr <= a;
    wdata <= d;
    wr_req <= wr;
    rd_req <= ~wr;
    t = 0;
    do begin
      @(negedge mclk_i);
      w = waitreq;
      rd = rdata;
      @(posedge mclk_i);
      t++;
    end while (w !== 1'h0 && t < 20);
    if (w !== 1'h0) begin
      error_cnt++;
      tally_and_finish();
    end
    wr_req <= 1'h0;
    rd_req <= 1'h0;
  endtask : bus

  task automatic count_pulses(input int n);
    logic [11:0] v;
    for (int k = 0; k < 12; k++) cnt[k] = 0;
    repeat (n) begin
      @(negedge mclk_i);
      v = {main_t, ring_t, cpu_en, wdt_en, f1, f2, f8, f32, s1, s2, s8, s32};
      for (int k = 0; k < 12; k++) cnt[k] += int'(v[11-k]);
    end
    @(posedge mclk_i);
  endtask : count_pulses

  task automatic set_mode(input logic [2:0] m, input logic ps);
    bus(1'h1, `CC_OFF_MODE_B, {24'h0, m[1:0], 6'h0});
    bus(1'h1, `CC_OFF_MODE_A, {24'h0, 1'h0, m[2], 3'h0, ps, 2'h0});
    repeat (400) @(posedge mclk_i);
  endtask : set_mode

  task automatic wake(input logic ext);
    int t;
    if (ext) ext_irq <= 1'h1;
    else irq <= 1'h1;
    t = 0;
    do begin
      @(negedge mclk_i);
      t++;
    end while (halt !== 1'h0 && t < 10);
    @(posedge mclk_i);
    ext_irq <= 1'h0;
    irq <= 1'h0;
    check(32'(halt), 32'h0);
  endtask : wake

  function automatic int ratio_of(input logic [2:0] m);
    if (m[2]) return 8;
    case (m[1:0])
      2'h0: return 1;
      2'h1: return 2;
      2'h2: return 4;
      default: return 16;
    endcase
  endfunction : ratio_of

  initial begin
    reset_i = 1'h1;
    osc_run = 1'h1;
    osc_half = 8'h0F;
    {rd_req, wr_req, irq, ext_irq} = 4'h0;
    addr = 5'h00;
    wdata = 32'h0;
    error_cnt = 0;
    comparisons = 0;
    void'($urandom(77));
    repeat (5) @(posedge mclk_i);
    reset_i <= 1'h0;
    bus(1'h0, `CC_OFF_MODE_A, 32'h0);
    check(rd, 32'h40);
    bus(1'h0, `CC_OFF_STAT, 32'h0);
    check(rd, 32'h70);
    bus(1'h1, 5'h18, 32'hFF);
    bus(1'h0, 5'h18, 32'h0);
    check(rd, 32'h0);
    $display("Test reset done");
    h = 3 * (1 + $urandom % 6);
    osc_half <= 8'(h);
    repeat (400) @(posedge mclk_i);
    count_pulses(24 * h);
    check(32'(cnt[0] >= 35 && cnt[0] <= 37), 32'h1);
    osc_run <= 1'h0;
    count_pulses(24 * h);
    check(32'(cnt[0] >= 35 && cnt[0] <= 37), 32'h1);
    osc_run <= 1'h1;
    osc_half <= 8'h0F;
    repeat (400) @(posedge mclk_i);
    $display("Test main clock done");
    s = $urandom % 6;
    for (int i = 0; i < 6; i++) begin
      b = tbl[(i + s) % 6];
      r = ratio_of(b);
      set_mode(b, 1'h0);
      bus(1'h0, `CC_OFF_STAT, 32'h0);
      check(32'(rd[7:4]), 32'(r - 1));
      count_pulses(640);
      check(32'(cnt[2]), 32'(64 / r));
      for (int k = 0; k < 4; k++) begin
        check(32'(cnt[4+k]), 32'(64 / fdiv[k]));
        check(32'(cnt[8+k]), 32'(64 / fdiv[k]));
      end
    end
    $display("Test divider done");
    set_mode(3'h2, 1'h0);
    bus(1'h1, `CC_OFF_CMD, 32'h1);
    repeat (2) @(posedge mclk_i);
    check(32'(halt), 32'h1);
    check(32'(hold), 32'h1);
    bus(1'h1, `CC_OFF_MODE_A, 32'h40);
    count_pulses(640);
    check(32'(cnt[2]), 32'h0);
    check(32'(cnt[3]), 32'h0);
    check(32'(cnt[4]), 32'd64);
    wake(1'h0);
    check(32'(hold), 32'h0);
    count_pulses(640);
    check(32'(cnt[2]), 32'd16);
    bus(1'h0, `CC_OFF_STAT, 32'h0);
    check(32'(rd[7:3]), 32'h06);
    $display("Test wait irq done");
    set_mode(3'h2, 1'h1);
    bus(1'h1, `CC_OFF_CMD, 32'h1);
    repeat (2) @(posedge mclk_i);
    count_pulses(320);
    check(32'(cnt[4] + cnt[7] + cnt[8] + cnt[11]), 32'h0);
    check(32'(cnt[0]), 32'd32);
    irq <= 1'h1;
    repeat (20) @(posedge mclk_i);
    check(32'(halt), 32'h1);
    irq <= 1'h0;
    wake(1'h1);
    count_pulses(640);
    check(32'(cnt[4]), 32'd64);
    $display("Test wait gated done");
    set_mode(3'h2, 1'h0);
    bus(1'h1, `CC_OFF_PROC_C, 32'h4);
    bus(1'h1, `CC_OFF_MODE_C, 32'h2);
    repeat (4000) @(posedge mclk_i);
    check(32'(ring_on), 32'h1);
    count_pulses(3200);
    check(32'(cnt[1]), 32'd32);
    check(32'(cnt[6]), 32'd4);
    check(32'(cnt[2]), 32'd8);
    bus(1'h1, `CC_OFF_CMD, 32'h1);
    repeat (2) @(posedge mclk_i);
    count_pulses(500);
    check(32'(cnt[3] >= 4), 32'h1);
    check(32'(cnt[2]), 32'h0);
    wake(1'h0);
    set_mode(3'h4, 1'h0);
    bus(1'h1, `CC_OFF_MODE_C, 32'h0);
    repeat (4000) @(posedge mclk_i);
    check(32'(ring_on), 32'h0);
    count_pulses(640);
    check(32'(cnt[2]), 32'h8);
    $display("Test internal oscillator done");
    set_mode(3'h0, 1'h0);
    bus(1'h1, `CC_OFF_MODE_B, 32'h1);
    repeat (3) @(posedge mclk_i);
    count_pulses(300);
    check(32'(cnt[0] + cnt[2] + cnt[4]), 32'h0);
    check(32'(halt), 32'h1);
    check(32'(osc_out), 32'h0);
    wake(1'h1);
    bus(1'h0, `CC_OFF_MODE_A, 32'h0);
    check(32'(rd[6]), 32'h1);
    $display("Test stop done");
    bus(1'h1, `CC_OFF_CMD, 32'h1);
    repeat (2) @(posedge mclk_i);
    check(32'(halt), 32'h1);
    reset_i <= 1'h1;
    repeat (5) @(posedge mclk_i);
    reset_i <= 1'h0;
    check(32'(halt), 32'h0);
    bus(1'h0, `CC_OFF_MODE_A, 32'h0);
    check(rd, 32'h40);
    $display("Test reset wake done");
    tally_and_finish();
  end
endmodule : tb_top
